// file: logic/cprc_link_if.sv
// Pin-level link between the PROM reset control and the target's config logic
interface cprc_link_if;
    logic target_config_clock;
    logic reset_oe_prom_oe_n;
    logic reset_oe_tgt_oe_n;
    logic reset_oe_level;
    logic chip_enable_n;
    logic chain_enable_out_n;
    logic data_oe_n;
    logic [7:0] data;
    logic config_pulse_n_o;
    logic config_pulse_n_oe_n;
    logic config_pulse_n_level;
    logic busy;
    logic prom_clock_out;
    logic prom_clock_out_oe_n;
    logic target_select_n;
    logic target_write_dir_n;

    // Reset line open-drain with pull-up: low if anyone enables its driver; pulse pin follows its driver when enabled, else pulled high
    assign reset_oe_level = reset_oe_prom_oe_n & reset_oe_tgt_oe_n;
    assign config_pulse_n_level = config_pulse_n_oe_n ? 1'b1 : config_pulse_n_o;

    modport prom (
        input target_config_clock, reset_oe_level, chip_enable_n, busy,
        input config_pulse_n_level,
        output reset_oe_prom_oe_n, chain_enable_out_n, data_oe_n, data,
        output config_pulse_n_o, config_pulse_n_oe_n, prom_clock_out,
        output prom_clock_out_oe_n
    );
    modport target (
        input reset_oe_level, chain_enable_out_n, data_oe_n, data,
        input config_pulse_n_level, prom_clock_out, prom_clock_out_oe_n,
        output target_config_clock, reset_oe_tgt_oe_n, chip_enable_n, busy,
        output target_select_n, target_write_dir_n
    );
endinterface

// file: logic/cprc_pkg.sv
// Shared constants and types for the configuration PROM reset control
package cprc_pkg;
    // ============================================================
    // Widths and variants
    localparam int ADDR_W = 16;
    localparam int POR_SYNC_STAGES = 3;
    typedef enum logic [0:0] {
        CPRC_SERIAL_ONLY = 1'b0,
        CPRC_PARALLEL = 1'b1
    } cprc_variant_t;
    // ============================================================
    // Reset release delay
    localparam int RESET_RELEASE_DELAY_NS = 2000;
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int RELEASE_CYCLES =
        (RESET_RELEASE_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int RELEASE_CNT_W = 8;
    // ============================================================
    // Reset values and clock output divider half-period
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic [RELEASE_CNT_W-1:0] RELEASE_CNT_RESET = 8'h00;
    localparam logic [3:0] CLK_DIV_HALF = 4'h3;
    // ============================================================
    // Power sequencer states
    typedef enum logic [1:0] {
        CPRC_PWR_RAMP = 2'b00,
        CPRC_PWR_WAIT = 2'b01,
        CPRC_PWR_UP = 2'b10
    } cprc_pwr_state_t;
endpackage

// file: logic/cprc_prom.sv
// Configuration PROM end: power-on reset, release delay and address counter
// ============================================================
// What this block does
// - Hold reset line low while supplies ramp
// - Wait release delay after thresholds crossed
// - Brown-out resets and holds line low
// - Serial variant needs only core supply
// - Parallel variant also needs output supply
// - External monitor may hold line low
// - Target starts configuring on high line
// - Reset on line low or chip-enable high
// - Reset clears address, chain-enable high, outputs float
// - Reset line always active low
// - Pulse pin output-only serial, two-way parallel
// - Busy input only on parallel variant
// - Busy needed only for fast parallel mode
// - External clock when clock output disabled
// - Target select and write-dir held low
// - Count address on each rising config clock edge that busy does not hold
module cprc_prom #(
    parameter cprc_pkg::cprc_variant_t VARIANT = cprc_pkg::CPRC_PARALLEL,
    parameter int RELEASE_CNT = cprc_pkg::RELEASE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Supply monitors, asynchronous
    input wire logic core_supply_ok,
    input wire logic output_supply_ok,
    // Options and user data
    input wire logic clock_out_enable,
    input wire logic use_busy,
    input wire logic [7:0] mem_data,
    input wire logic config_pulse_req,
    // User status
    output logic powered_up,
    output logic [cprc_pkg::ADDR_W-1:0] address,
    // Link
    cprc_link_if.prom link
);
    import cprc_pkg::*;

    // ============================================================
    // Supply synchronisers, three stages, second and third agree
    logic [2:0] core_sync_r;
    logic [2:0] out_sync_r;
    logic core_ok_r;
    logic out_ok_r;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            core_sync_r <= 3'h0;
            out_sync_r <= 3'h0;
            core_ok_r <= 1'b0;
            out_ok_r <= 1'b0;
        end else begin
            core_sync_r <= {core_sync_r[1:0], core_supply_ok};
            out_sync_r <= {out_sync_r[1:0], output_supply_ok};
            if (core_sync_r[2] == core_sync_r[1]) begin
                core_ok_r <= core_sync_r[2];
            end
            if (out_sync_r[2] == out_sync_r[1]) begin
                out_ok_r <= out_sync_r[2];
            end
        end
    end

    // Variant decides which supplies gate the release
    wire supplies_ok = (VARIANT == CPRC_PARALLEL) ? (core_ok_r & out_ok_r)
                                                  : core_ok_r;

    // ============================================================
    // Power sequencer
    cprc_pwr_state_t state_r;
    cprc_pwr_state_t state_nxt;
    logic [RELEASE_CNT_W-1:0] cnt_r;
    logic [RELEASE_CNT_W-1:0] cnt_nxt;
    wire delay_done = (cnt_r >= RELEASE_CNT_W'(RELEASE_CNT - 1));

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            CPRC_PWR_RAMP: begin
                cnt_nxt = RELEASE_CNT_RESET;
                if (supplies_ok) begin
                    state_nxt = CPRC_PWR_WAIT;
                end
            end
            CPRC_PWR_WAIT: begin
                cnt_nxt = cnt_r + RELEASE_CNT_W'(1);
                if (!supplies_ok) begin
                    state_nxt = CPRC_PWR_RAMP;
                end else if (delay_done) begin
                    state_nxt = CPRC_PWR_UP;
                end
            end
            CPRC_PWR_UP: begin
                if (!supplies_ok) begin
                    state_nxt = CPRC_PWR_RAMP;
                end
            end
            default: begin
                state_nxt = CPRC_PWR_RAMP;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= CPRC_PWR_RAMP;
            cnt_r <= RELEASE_CNT_RESET;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Line driven low (oe_n=0) until powered; never driven high
    logic hold_low_r;
    logic powered_r;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hold_low_r <= 1'b1;
            powered_r <= 1'b0;
        end else begin
            hold_low_r <= (state_nxt != CPRC_PWR_UP);
            powered_r <= (state_nxt == CPRC_PWR_UP);
        end
    end
    assign link.reset_oe_prom_oe_n = ~hold_low_r;
    assign powered_up = powered_r;

    // ============================================================
    // Powered flag into the config-clock domain
    logic [1:0] pwr_cc_r;
    always_ff @(posedge link.target_config_clock or posedge sys_rst) begin
        if (sys_rst) begin
            pwr_cc_r <= 2'b00;
        end else begin
            pwr_cc_r <= {pwr_cc_r[0], powered_r};
        end
    end

    // Reset seen on the line or chip enable; level asynchronous
    wire prom_in_reset = ~pwr_cc_r[1] | ~link.reset_oe_level | link.chip_enable_n;
    wire busy_hold = (VARIANT == CPRC_PARALLEL) & use_busy & link.busy;

    logic [ADDR_W-1:0] addr_r;
    logic active_r;
    always_ff @(posedge link.target_config_clock or posedge prom_in_reset) begin
        if (prom_in_reset) begin
            addr_r <= ADDR_RESET;
            active_r <= 1'b0;
        end else begin
            active_r <= 1'b1;
            if (!busy_hold) begin
                addr_r <= addr_r + ADDR_W'(1);
            end
        end
    end
    assign address = addr_r;

    // ============================================================
    // Outputs: chain enable high and outputs floating in reset
    assign link.chain_enable_out_n = 1'b1;
    assign link.data_oe_n = ~active_r | prom_in_reset;
    assign link.data = mem_data;

    // Clock output, divided from clock, floats in reset
    logic [3:0] div_r;
    logic clk_out_r;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            div_r <= 4'h0;
            clk_out_r <= 1'b0;
        end else if (div_r == CLK_DIV_HALF) begin
            div_r <= 4'h0;
            clk_out_r <= ~clk_out_r;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end
    assign link.prom_clock_out = clk_out_r;
    assign link.prom_clock_out_oe_n = ~(clock_out_enable & powered_r & link.reset_oe_level
                                        & ~link.chip_enable_n
                                        & (VARIANT == CPRC_PARALLEL));

    // Pulse pin: output-only drives both levels, two-way drives only low
    logic cf_r;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cf_r <= 1'b0;
        end else begin
            cf_r <= config_pulse_req;
        end
    end
    assign link.config_pulse_n_o = ~cf_r;
    assign link.config_pulse_n_oe_n = (VARIANT == CPRC_PARALLEL) ? ~cf_r : 1'b0;
endmodule

// file: logic/cprc_target.sv
// Target end: configuration logic facing the PROM
module cprc_target (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // User control
    input wire logic monitor_hold,
    input wire logic config_done,
    input wire logic target_busy,
    input wire logic use_prom_clock,
    // User status
    output logic config_permit,
    output logic [7:0] data_seen,
    // Link
    cprc_link_if.target link
);
    import cprc_pkg::*;

    // ============================================================
    // Init level, three stages, second and third agree
    logic [2:0] init_sync_r;
    logic permit_r;
    logic [7:0] data_r;
    logic hold_r;
    logic done_r;
    logic busy_r;
    logic ext_clk_r;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            init_sync_r <= 3'h0;
            permit_r <= 1'b0;
            data_r <= 8'h00;
            hold_r <= 1'b1;
            done_r <= 1'b0;
            busy_r <= 1'b0;
            ext_clk_r <= 1'b0;
        end else begin
            init_sync_r <= {init_sync_r[1:0], link.reset_oe_level};
            if (init_sync_r[2] == init_sync_r[1]) begin
                permit_r <= init_sync_r[2];
            end
            if (!link.data_oe_n) begin
                data_r <= link.data;
            end
            hold_r <= monitor_hold;
            done_r <= config_done;
            busy_r <= target_busy;
            ext_clk_r <= ~ext_clk_r;
        end
    end
    assign config_permit = permit_r;
    assign data_seen = data_r;
    assign link.reset_oe_tgt_oe_n = ~hold_r;
    assign link.chip_enable_n = done_r;
    assign link.busy = busy_r;
    // Own clock when the PROM clock output is not used
    // Released clock output sits at its pull-up level
    wire prom_clk_seen = link.prom_clock_out_oe_n ? 1'b1 : link.prom_clock_out;
    assign link.target_config_clock = use_prom_clock ? prom_clk_seen
                                                     : ext_clk_r;
    assign link.target_select_n = 1'b0;
    assign link.target_write_dir_n = 1'b0;
endmodule

// file: testbench/cprc_props.sv
// Concurrent checks on the PROM-to-target link
module cprc_props (
    // Clocks and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic target_config_clock,
    // Link signals
    input wire logic reset_oe_prom_oe_n,
    input wire logic reset_oe_tgt_oe_n,
    input wire logic reset_oe_level,
    input wire logic chip_enable_n,
    input wire logic chain_enable_out_n,
    input wire logic data_oe_n,
    input wire logic prom_clock_out_oe_n,
    input wire logic target_select_n,
    input wire logic target_write_dir_n
);
    timeunit 1ns;
    timeprecision 1ps;
    chk_hold_at_start: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(sys_rst) |-> !reset_oe_prom_oe_n [*5]) else $error("line released early");
    chk_chain_high: assert property (@(posedge clock) disable iff (sys_rst)
        chain_enable_out_n) else $error("chain enable went low");
    chk_line_low_float: assert property (@(posedge clock) disable iff (sys_rst)
        !reset_oe_level [*3] |-> data_oe_n && prom_clock_out_oe_n)
        else $error("outputs driven while line low");
    chk_ce_float: assert property (@(posedge clock) disable iff (sys_rst)
        chip_enable_n [*3] |-> data_oe_n) else $error("data driven while disabled");
    chk_prom_clock_out_ce: assert property (@(posedge clock) disable iff (sys_rst)
        chip_enable_n [*3] |-> prom_clock_out_oe_n) else $error("clock out driven");
    chk_select_low: assert property (@(posedge clock) disable iff (sys_rst)
        !target_select_n && !target_write_dir_n) else $error("select or write high");
    chk_link_float: assert property (@(posedge target_config_clock) disable iff (sys_rst)
        !reset_oe_level |=> data_oe_n) else $error("data driven in reset");
    chk_target_hold: assert property (@(posedge clock) disable iff (sys_rst)
        !reset_oe_tgt_oe_n |-> data_oe_n && prom_clock_out_oe_n)
        else $error("outputs driven while far side holds line");
endmodule

// file: testbench/cprc_test.sv
// Bench joining the PROM end and the target end over the link
module cprc_test;
    import cprc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REL = 3;
    logic clock = 0, link_clk = 0, sys_rst = 1, core_ok = 0, out_ok = 0;
    logic clk_out_en = 0, use_busy = 0, pulse_req = 0, mon_hold = 0;
    logic cfg_done = 0, tgt_busy = 0, use_pclk = 0, powered_up, config_permit, s_powered;
    logic [7:0] mem_data = 8'hA5, data_seen;
    logic [ADDR_W-1:0] address, a, s_addr, sa;
    int fails = 0, n_checks = 0, cycles = 0, n;
    always #50 clock = ~clock;
    initial begin
        #7;
        forever #32 link_clk = ~link_clk;
    end
    cprc_link_if cprc_link_if_inst ();
    cprc_prom #(.VARIANT(CPRC_PARALLEL), .RELEASE_CNT(REL)) cprc_prom_inst (
        .clock(clock), .sys_rst(sys_rst), .core_supply_ok(core_ok),
        .output_supply_ok(out_ok), .clock_out_enable(clk_out_en), .use_busy(use_busy),
        .mem_data(mem_data), .config_pulse_req(pulse_req), .powered_up(powered_up),
        .address(address), .link(cprc_link_if_inst));
    cprc_target cprc_target_inst (
        .clock(link_clk), .sys_rst(sys_rst), .monitor_hold(mon_hold),
        .config_done(cfg_done), .target_busy(tgt_busy), .use_prom_clock(use_pclk),
        .config_permit(config_permit), .data_seen(data_seen), .link(cprc_link_if_inst));
    // Serial-only pair, output supply and busy must not matter
    cprc_link_if ser_link ();
    cprc_prom #(.VARIANT(CPRC_SERIAL_ONLY), .RELEASE_CNT(REL)) cprc_prom_ser_inst (
        .clock(clock), .sys_rst(sys_rst), .core_supply_ok(core_ok),
        .output_supply_ok(out_ok), .clock_out_enable(clk_out_en), .use_busy(use_busy),
        .mem_data(mem_data), .config_pulse_req(pulse_req), .powered_up(s_powered),
        .address(s_addr), .link(ser_link));
    cprc_target cprc_target_ser_inst (
        .clock(link_clk), .sys_rst(sys_rst), .monitor_hold(mon_hold),
        .config_done(cfg_done), .target_busy(tgt_busy), .use_prom_clock(use_pclk),
        .config_permit(), .data_seen(), .link(ser_link));
    cprc_props cprc_props_inst (
        .clock(clock), .sys_rst(sys_rst),
        .target_config_clock(cprc_link_if_inst.target_config_clock),
        .reset_oe_prom_oe_n(cprc_link_if_inst.reset_oe_prom_oe_n),
        .reset_oe_tgt_oe_n(cprc_link_if_inst.reset_oe_tgt_oe_n),
        .reset_oe_level(cprc_link_if_inst.reset_oe_level),
        .chip_enable_n(cprc_link_if_inst.chip_enable_n),
        .chain_enable_out_n(cprc_link_if_inst.chain_enable_out_n),
        .data_oe_n(cprc_link_if_inst.data_oe_n),
        .prom_clock_out_oe_n(cprc_link_if_inst.prom_clock_out_oe_n),
        .target_select_n(cprc_link_if_inst.target_select_n),
        .target_write_dir_n(cprc_link_if_inst.target_write_dir_n));
    // ============================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic wait_rel();
        n = 0;
        while (cprc_link_if_inst.reset_oe_prom_oe_n !== 1'b1 && n < 60) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            stop_test();
        end
    end
    // ============================================================
    // Scenarios
    task automatic t_power();
        @(posedge clock) core_ok <= 1'b1;
        cyc(30);
        check(cprc_link_if_inst.reset_oe_level, 1'b0);
        check(powered_up, 1'b0);
        check(ser_link.reset_oe_prom_oe_n, 1'b1);
        check(s_powered, 1'b1);
        @(posedge clock) out_ok <= 1'b1;
        wait_rel();
        check(n >= REL && n < 60, 1'b1);
        cyc(10);
        check(config_permit, 1'b1);
        $display("power-up test done");
    endtask
    task automatic t_count();
        cyc(40);
        check(address != 0, 1'b1);
        check(data_seen, 8'hA5);
        @(posedge clock) {use_pclk, clk_out_en} <= 2'b11;
        a = address;
        cyc(80);
        check(address != a, 1'b1);
        @(posedge clock) cfg_done <= 1'b1;
        cyc(10);
        check(cprc_link_if_inst.chip_enable_n, 1'b1);
        check(address, 16'h0000);
        check(cprc_link_if_inst.data_oe_n, 1'b1);
        @(posedge clock) {cfg_done, use_pclk} <= 2'b00;
        $display("count test done");
    endtask
    task automatic t_hold();
        @(posedge clock) mon_hold <= 1'b1;
        cyc(10);
        check(cprc_link_if_inst.reset_oe_level, 1'b0);
        check(address, 16'h0000);
        check(config_permit, 1'b0);
        @(posedge clock) mon_hold <= 1'b0;
        cyc(40);
        check(address != 0, 1'b1);
        $display("monitor hold test done");
    endtask
    task automatic t_brown();
        @(posedge clock) core_ok <= 1'b0;
        cyc(10);
        check(cprc_link_if_inst.reset_oe_prom_oe_n, 1'b0);
        check(powered_up, 1'b0);
        check(address, 16'h0000);
        @(posedge clock) core_ok <= 1'b1;
        wait_rel();
        check(n >= REL && n < 60, 1'b1);
        $display("brown-out test done");
    endtask
    task automatic t_busy();
        @(posedge clock) {use_busy, tgt_busy} <= 2'b11;
        cyc(10);
        a = address;
        sa = s_addr;
        cyc(20);
        check(address, a);
        check(s_addr != sa, 1'b1);
        @(posedge clock) tgt_busy <= 1'b0;
        cyc(20);
        check(address != a, 1'b1);
        @(posedge clock) use_busy <= 1'b0;
        @(posedge clock) pulse_req <= 1'b1;
        cyc(4);
        check(cprc_link_if_inst.config_pulse_n_level, 1'b0);
        check(ser_link.config_pulse_n_level, 1'b0);
        @(posedge clock) pulse_req <= 1'b0;
        cyc(4);
        check(cprc_link_if_inst.config_pulse_n_level, 1'b1);
        check(cprc_link_if_inst.config_pulse_n_oe_n, 1'b1);
        check(ser_link.config_pulse_n_oe_n, 1'b0);
        check(ser_link.config_pulse_n_level, 1'b1);
        $display("busy and pulse test done");
    endtask
    initial begin
        cyc(8);
        @(posedge clock) sys_rst <= 1'b0;
        t_power();
        t_count();
        t_hold();
        t_brown();
        t_busy();
        stop_test();
    end
endmodule
